//--- pqo_phase_to_quadrature_output.sv
// Notes on behaviour
// - Offset register adds onto phase bits 31:16, giving the lookup phase.
// - Source select high loads the offset from the phase input register.
// - Source select low puts the PSK code in offset bits 15:13, rest cleared.
// - PSK codes map 0,45,90,135,270,315,180,225 degrees.
// - Offset register loads only while its low-true load enable is low.
// - Timer accumulator adds the timer increment every clock.
// - Timer increment captures the input register while its load is low.
// - Timer carry output is the accumulator carry, inverted.
// - Lookup uses the top 20 phase bits, gives 16-bit sine and cosine.
// - Address zero is 0 radians; each step is one 2^20th of a turn.
// - Two's complement samples span 8001 to 7FFF around midscale.
// - Offset binary inverts both sample MSBs, spanning 0001 to FFFF.
// - Serial shifters load while accumulator enable is low, else shift.
// - MSB-first streams leave on bit 15, LSB-first on bit 0.
// - MSB-first streams fill with zeros after the last bit.
// - LSB-first streams repeat the sign bit after the MSB.
// - Converter strobe goes low as the first bit of a new word appears.
// - Test plus parallel select shows the 28 lookup phase MSBs.
// - In test, sine pins hold the upper word, cosine pins the rest.
// - Load enables are registered; the target loads on the next edge.
// - Phase sums wrap, keeping the low 32 bits.
// - Converter strobe stays high in parallel mode.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pqo_phase_to_quadrature_output (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic        pready,
	output var  logic [31:0] prdata,
	output var  logic        pslverr,
	input  wire logic [31:0] accumulated_phase,
	input  wire logic [2:0]  psk_phase_code,
	input  wire logic        phase_offset_load_n,
	input  wire logic        timer_increment_load_n,
	input  wire logic        accumulator_enable_n,
	output var  logic [15:0] sine_out,
	output var  logic [15:0] cosine_out,
	output var  logic        converter_strobe_n,
	output var  logic        timer_carry_out_n
);

	pqo_pkg::pqo_ctrl_s ctrl;
	logic [15:0]        phase_in;
	logic [31:0]        tinc_in;
	logic [31:0]        timer_inc;
	logic [31:0]        timer_acc;
	logic [15:0]        phase_offset;
	logic [31:0]        phase_inst;
	logic               po_load_q;
	logic               ti_load_q;
	logic [32:0]        timer_sum;
	logic               apb_write;
	logic               serial_mode;
	logic               test_active;

	logic signed [19:0] cx [0:16];
	logic signed [19:0] cy [0:16];
	logic signed [23:0] cz [0:16];
	logic [1:0]         cq [0:16];
	logic [15:0]        sin_raw;
	logic [15:0]        cos_raw;
	logic [15:0]        sin_word;
	logic [15:0]        cos_word;

	logic [15:0]        sin_msb;
	logic [15:0]        sin_lsb;
	logic [15:0]        cos_msb;
	logic [15:0]        cos_lsb;
	logic [15:0]        next_sin_msb;
	logic [15:0]        next_sin_lsb;
	logic [15:0]        next_cos_msb;
	logic [15:0]        next_cos_lsb;

	function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : byte_merge

	// Codes 1xx swap the 180 and 270 degree halves
	function automatic logic [2:0] psk_map(input logic [2:0] code);
		return {code[2], code[2] ^ code[1], code[0]};
	endfunction : psk_map

	// Clamp keeps the symmetric span, so 8000 never appears
	function automatic logic [15:0] sat16(input logic signed [19:0] v);
		if (v > pqo_pkg::SAMPLE_MAX)
		begin
			return pqo_pkg::SAMPLE_MAX[15:0];
		end
		else if (v < pqo_pkg::SAMPLE_MIN)
		begin
			return pqo_pkg::SAMPLE_MIN[15:0];
		end
		return v[15:0];
	endfunction : sat16

	function automatic logic [15:0] fmt(input logic [15:0] w, input logic obin_n);
		return {w[15] ^ ~obin_n, w[14:0]};
	endfunction : fmt

	assign apb_write   = psel && penable && pready && pwrite;
	assign serial_mode = !ctrl.parallel_serial_select;
	assign test_active = ctrl.test_mode && ctrl.parallel_serial_select;
	assign timer_sum   = {1'b0, timer_acc} + {1'b0, timer_inc};
	assign sin_word    = fmt(sin_raw, ctrl.offset_binary_select_n);
	assign cos_word    = fmt(cos_raw, ctrl.offset_binary_select_n);

	// Setup phase registers every answer, so it comes from a flip-flop with no wait state
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel && !penable)
		begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			case (paddr)
				pqo_pkg::CTRL_OFFSET:     prdata <= {28'h0000000, ctrl};
				pqo_pkg::PHASE_IN_OFFSET: prdata <= {16'h0000, phase_in};
				pqo_pkg::TINC_IN_OFFSET:  prdata <= tinc_in;
				pqo_pkg::TINC_OFFSET:     prdata <= timer_inc;
				pqo_pkg::TACC_OFFSET:     prdata <= timer_acc;
				default:
				begin
					prdata  <= 32'h00000000;
					pslverr <= 1'b1;
				end
			endcase
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl     <= pqo_pkg::CTRL_RESET;
			phase_in <= pqo_pkg::PHASE_IN_RESET;
			tinc_in  <= pqo_pkg::TINC_RESET;
		end
		else if (apb_write)
		begin
			case (paddr)
				pqo_pkg::CTRL_OFFSET:
				begin
					if (pstrb[0])
					begin
						ctrl <= pqo_pkg::pqo_ctrl_s'(pwdata[3:0]);
					end
				end
				pqo_pkg::PHASE_IN_OFFSET:
				begin
					phase_in <= 16'(byte_merge({16'h0000, phase_in}, pwdata, pstrb));
				end
				pqo_pkg::TINC_IN_OFFSET:
				begin
					tinc_in <= byte_merge(tinc_in, pwdata, pstrb);
				end
				default:
				begin
					ctrl <= ctrl;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			po_load_q <= 1'b1;
			ti_load_q <= 1'b1;
		end
		else
		begin
			po_load_q <= phase_offset_load_n;
			ti_load_q <= timer_increment_load_n;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			phase_offset <= pqo_pkg::OFFSET_RESET;
		end
		else if (!po_load_q)
		begin
			if (ctrl.phase_source_select)
			begin
				phase_offset <= phase_in;
			end
			else
			begin
				phase_offset <= {psk_map(psk_phase_code), 13'h0000};
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			phase_inst <= 32'h00000000;
		end
		else
		begin
			phase_inst <= accumulated_phase + {phase_offset, 16'h0000};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			timer_inc         <= pqo_pkg::TINC_RESET;
			timer_acc         <= 32'h00000000;
			timer_carry_out_n <= 1'b1;
		end
		else
		begin
			if (!ti_load_q)
			begin
				timer_inc <= tinc_in;
			end
			timer_acc         <= timer_sum[31:0];
			timer_carry_out_n <= !timer_sum[32];
		end
	end

	// Quadrant from bits 31:30, residual angle from the next 18 bits
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i <= pqo_pkg::CORDIC_STAGES; i++)
			begin
				cx[i] <= 20'sh00000;
				cy[i] <= 20'sh00000;
				cz[i] <= 24'sh000000;
				cq[i] <= 2'h0;
			end
		end
		else
		begin
			cx[0] <= pqo_pkg::CORDIC_X0;
			cy[0] <= 20'sh00000;
			cz[0] <= {4'h0, phase_inst[29:12], 2'h0};
			cq[0] <= phase_inst[31:30];
			for (int i = 0; i < pqo_pkg::CORDIC_STAGES; i++)
			begin
				cq[i+1] <= cq[i];
				if (cz[i][23])
				begin
					cx[i+1] <= cx[i] + (cy[i] >>> i);
					cy[i+1] <= cy[i] - (cx[i] >>> i);
					cz[i+1] <= cz[i] + pqo_pkg::ATAN_TABLE[i];
				end
				else
				begin
					cx[i+1] <= cx[i] - (cy[i] >>> i);
					cy[i+1] <= cy[i] + (cx[i] >>> i);
					cz[i+1] <= cz[i] - pqo_pkg::ATAN_TABLE[i];
				end
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sin_raw <= 16'h0000;
			cos_raw <= 16'h0000;
		end
		else
		begin
			case (cq[16])
				2'h0:
				begin
					sin_raw <= sat16(cy[16]);
					cos_raw <= sat16(cx[16]);
				end
				2'h1:
				begin
					sin_raw <= sat16(cx[16]);
					cos_raw <= sat16(-cy[16]);
				end
				2'h2:
				begin
					sin_raw <= sat16(-cy[16]);
					cos_raw <= sat16(-cx[16]);
				end
				default:
				begin
					sin_raw <= sat16(-cx[16]);
					cos_raw <= sat16(cy[16]);
				end
			endcase
		end
	end

	// Shifters run in every mode so a switch to serial starts clean
	always_comb
	begin
		if (!accumulator_enable_n)
		begin
			next_sin_msb = sin_word;
			next_sin_lsb = sin_word;
			next_cos_msb = cos_word;
			next_cos_lsb = cos_word;
		end
		else
		begin
			next_sin_msb = {sin_msb[14:0], 1'b0};
			next_cos_msb = {cos_msb[14:0], 1'b0};
			next_sin_lsb = {sin_lsb[15], sin_lsb[15:1]};
			next_cos_lsb = {cos_lsb[15], cos_lsb[15:1]};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sin_msb <= 16'h0000;
			sin_lsb <= 16'h0000;
			cos_msb <= 16'h0000;
			cos_lsb <= 16'h0000;
		end
		else
		begin
			sin_msb <= next_sin_msb;
			sin_lsb <= next_sin_lsb;
			cos_msb <= next_cos_msb;
			cos_lsb <= next_cos_lsb;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sine_out           <= 16'h0000;
			cosine_out         <= 16'h0000;
			converter_strobe_n <= 1'b1;
		end
		else
		begin
			converter_strobe_n <= !(serial_mode && !accumulator_enable_n);
			if (serial_mode)
			begin
				sine_out   <= {next_sin_msb[15], 14'h0000, next_sin_lsb[0]};
				cosine_out <= {next_cos_msb[15], 14'h0000, next_cos_lsb[0]};
			end
			else if (test_active)
			begin
				sine_out   <= phase_inst[31:16];
				cosine_out <= {phase_inst[15:4], 4'h0};
			end
			else
			begin
				sine_out   <= sin_word;
				cosine_out <= cos_word;
			end
		end
	end

	a_offset_sum: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> phase_inst == $past(accumulated_phase) + {$past(phase_offset), 16'h0000})
		else $error("instantaneous phase not offset sum");

	a_source_input: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && !$past(po_load_q) && $past(ctrl.phase_source_select)
		|-> phase_offset == $past(phase_in))
		else $error("offset not loaded from phase input");

	a_psk_code: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && !$past(po_load_q) && !$past(ctrl.phase_source_select)
		|-> phase_offset == {psk_map($past(psk_phase_code)), 13'h0000})
		else $error("offset not formed from psk code");

	a_offset_hold: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $past(po_load_q) |-> $stable(phase_offset))
		else $error("offset changed without load enable");

	a_load_delay: assert property (@(posedge clk) disable iff (!rst_n)
		phase_offset_load_n ##1 (phase_offset_load_n && rst_n) |=> $stable(phase_offset))
		else $error("offset loaded too early");

	a_timer_step: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> timer_acc == $past(timer_acc) + $past(timer_inc))
		else $error("timer accumulator step wrong");

	a_inc_capture: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && !$past(ti_load_q) |-> timer_inc == $past(tinc_in))
		else $error("timer increment not captured");

	a_carry_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> timer_carry_out_n == !$past(timer_sum[32]))
		else $error("timer carry not tied to overflow");

	a_msb_shift: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $past(accumulator_enable_n) |-> sin_msb == {$past(sin_msb[14:0]), 1'b0})
		else $error("msb-first stream not zero filled");

	a_lsb_extend: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) && $past(accumulator_enable_n)
		|-> cos_lsb == {$past(cos_lsb[15]), $past(cos_lsb[15:1])})
		else $error("lsb-first stream not sign extended");

	a_strobe_mode: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl.parallel_serial_select |=> converter_strobe_n)
		else $error("strobe active in parallel mode");

	a_test_words: assert property (@(posedge clk) disable iff (!rst_n)
		test_active |=> sine_out == $past(phase_inst[31:16])
		&& cosine_out[15:4] == $past(phase_inst[15:4]))
		else $error("test mode address not shown");

endmodule : pqo_phase_to_quadrature_output

`default_nettype wire

//--- pqo_pkg.sv
package pqo_pkg;

	localparam logic [7:0] CTRL_OFFSET     = 8'h00;
	localparam logic [7:0] PHASE_IN_OFFSET = 8'h04;
	localparam logic [7:0] TINC_IN_OFFSET  = 8'h08;
	localparam logic [7:0] TINC_OFFSET     = 8'h0C;
	localparam logic [7:0] TACC_OFFSET     = 8'h10;

	localparam int CTRL_SRC_BIT  = 0;
	localparam int CTRL_OBIN_BIT = 1;
	localparam int CTRL_PSS_BIT  = 2;
	localparam int CTRL_TEST_BIT = 3;

	localparam logic [15:0] PHASE_IN_RESET = 16'h0000;
	localparam logic [31:0] TINC_RESET     = 32'h00000000;
	localparam logic [15:0] OFFSET_RESET   = 16'h0000;

	// Lookup pipeline
	localparam int CORDIC_STAGES = 16;
	localparam int PIPE_LATENCY  = 20;
	// Full scale divided by the rotation gain, trimmed low to stay below 7FFF
	localparam logic signed [19:0] CORDIC_X0 = 20'sh04DB9;
	localparam logic signed [19:0] SAMPLE_MAX = 20'sh07FFF;
	localparam logic signed [19:0] SAMPLE_MIN = -20'sh07FFF;

	// Arctangent of 2^-i, one turn is 2^22
	localparam logic [23:0] ATAN_TABLE [0:15] = '{
		24'h080000, 24'h04B902, 24'h027ECF, 24'h01444D,
		24'h00A2C3, 24'h005176, 24'h0028BE, 24'h00145F,
		24'h000A30, 24'h000518, 24'h00028C, 24'h000146,
		24'h0000A3, 24'h000051, 24'h000029, 24'h000014
	};

	typedef struct packed {
		logic test_mode;
		logic parallel_serial_select;
		logic offset_binary_select_n;
		logic phase_source_select;
	} pqo_ctrl_s;

	localparam pqo_ctrl_s CTRL_RESET = '{
		test_mode:              1'b0,
		parallel_serial_select: 1'b1,
		offset_binary_select_n: 1'b1,
		phase_source_select:    1'b0
	};

endpackage : pqo_pkg

//--- pqo_serial_sink.sv
`timescale 1ns/100ps
`default_nettype none

module pqo_serial_sink (
	input  wire logic        clk,
	output var  logic        accumulator_enable_n,
	input  wire logic [15:0] sine_out,
	input  wire logic [15:0] cosine_out,
	input  wire logic        converter_strobe_n
);
	initial accumulator_enable_n = 1'b1;

	// Collects one word from each of the four streams plus the strobe pattern
	task receive(output logic [15:0] s_msb, output logic [15:0] s_lsb,
		output logic [15:0] c_msb, output logic [15:0] c_lsb,
		output logic [15:0] strobes, output logic tail_ok);
		@(posedge clk);
		accumulator_enable_n <= 1'b0;
		@(posedge clk);
		accumulator_enable_n <= 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			// Sample off the edge so the registered outputs have landed
			#1;
			s_msb = {s_msb[14:0], sine_out[15]};
			c_msb = {c_msb[14:0], cosine_out[15]};
			s_lsb = {sine_out[0], s_lsb[15:1]};
			c_lsb = {cosine_out[0], c_lsb[15:1]};
			strobes = {strobes[14:0], converter_strobe_n};
			@(posedge clk);
		end
		#1;
		tail_ok = (sine_out[15] === 1'b0) && (cosine_out[15] === 1'b0) &&
			(sine_out[0] === s_msb[15]) && (cosine_out[0] === c_msb[15]);
		// Return on an edge so the caller drives right after it
		@(posedge clk);
	endtask : receive
endmodule : pqo_serial_sink

`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [31:0] accumulated_phase;
	logic [2:0]  psk_phase_code;
	logic        phase_offset_load_n;
	logic        timer_increment_load_n;
	logic        accumulator_enable_n;
	logic [15:0] sine_out;
	logic [15:0] cosine_out;
	logic        converter_strobe_n;
	logic        timer_carry_out_n;
	logic [31:0] rd;
	logic        err;
	logic [15:0] sm, sl, cm, cl, stb;
	logic        tail;
	int          failures = 0;
	int          checks = 0;
	int          cycles = 0;
	int          cnt;
	int          deg [8] = '{0, 45, 90, 135, 270, 315, 180, 225};
	logic [15:0] sq [4] = '{16'h0000, 16'h7FFF, 16'h0000, 16'h8001};
	logic [15:0] cq [4] = '{16'h7FFF, 16'h0000, 16'h8001, 16'h0000};

	pqo_phase_to_quadrature_output pqo_phase_to_quadrature_output_inst (
		.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .prdata, .pslverr, .accumulated_phase, .psk_phase_code,
		.phase_offset_load_n, .timer_increment_load_n, .accumulator_enable_n,
		.sine_out, .cosine_out, .converter_strobe_n, .timer_carry_out_n);

	pqo_serial_sink pqo_serial_sink_inst (
		.clk, .accumulator_enable_n, .sine_out, .cosine_out, .converter_strobe_n);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task end_sim();
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// Whole run is well under a thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			end_sim();
		end
	end

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Lookup is approximate, so samples get a small two's complement window
	task near(input string name, input logic [15:0] exp, input logic [15:0] got);
		int d;
		checks++;
		d = int'($signed(got)) - int'($signed(exp));
		if ($isunknown(got) || d > 8 || d < -8)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : near

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the cycle ceiling ends a wait
		while (pready !== 1'b1)
		begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : xfer

	task pulse_offset();
		phase_offset_load_n <= 1'b0;
		@(posedge clk);
		phase_offset_load_n <= 1'b1;
		repeat (5) @(posedge clk);
	endtask : pulse_offset

	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		accumulated_phase = 32'h0;
		psk_phase_code = 3'h0;
		phase_offset_load_n = 1'b1;
		timer_increment_load_n = 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		xfer(1'b0, pqo_pkg::CTRL_OFFSET, 32'h0);
		check("ctrl reset", 32'h6, rd);
		xfer(1'b0, 8'h14, 32'h0);
		check("unmapped error", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, rd);
		// Quarter of full scale gives a carry every fourth clock
		xfer(1'b1, pqo_pkg::TINC_IN_OFFSET, 32'h40000000);
		timer_increment_load_n <= 1'b0;
		@(posedge clk);
		timer_increment_load_n <= 1'b1;
		repeat (3) @(posedge clk);
		xfer(1'b1, pqo_pkg::TINC_OFFSET, 32'h1);
		xfer(1'b0, pqo_pkg::TINC_OFFSET, 32'h0);
		check("timer increment", 32'h40000000, rd);
		cnt = 0;
		repeat (40)
		begin
			@(posedge clk);
			if (timer_carry_out_n === 1'b0)
				cnt++;
		end
		check("carry pulses", 32'h0000000A, cnt);
		xfer(1'b1, pqo_pkg::PHASE_IN_OFFSET, 32'h1234);
		xfer(1'b1, pqo_pkg::CTRL_OFFSET, 32'hF);
		accumulated_phase <= 32'h00005678;
		pulse_offset();
		check("test sine", 32'h1234, {16'h0000, sine_out});
		check("test cosine", 32'h5670, {16'h0000, cosine_out});
		xfer(1'b1, pqo_pkg::PHASE_IN_OFFSET, 32'h4321);
		accumulated_phase <= 32'hF0000000;
		repeat (5) @(posedge clk);
		check("held offset", 32'h0234, {16'h0000, sine_out});
		xfer(1'b0, pqo_pkg::PHASE_IN_OFFSET, 32'h0);
		check("phase input", 32'h00004321, rd);
		pstrb <= 4'h1;
		xfer(1'b1, pqo_pkg::PHASE_IN_OFFSET, 32'h0000FFFF);
		pstrb <= 4'hF;
		xfer(1'b0, pqo_pkg::PHASE_IN_OFFSET, 32'h0);
		check("phase byte write", 32'h000043FF, rd);
		xfer(1'b1, pqo_pkg::CTRL_OFFSET, 32'hE);
		accumulated_phase <= 32'h0;
		for (int c = 0; c < 8; c++)
		begin
			psk_phase_code <= 3'(c);
			pulse_offset();
			check("psk offset", {16'h0, 3'(deg[c] / 45), 13'h0}, {16'h0000, sine_out});
		end
		psk_phase_code <= 3'h0;
		pulse_offset();
		xfer(1'b1, pqo_pkg::CTRL_OFFSET, 32'h6);
		for (int q = 0; q < 4; q++)
		begin
			accumulated_phase <= {2'(q), 30'h0};
			repeat (25) @(posedge clk);
			near("sine", sq[q], sine_out);
			near("cosine", cq[q], cosine_out);
		end
		xfer(1'b1, pqo_pkg::CTRL_OFFSET, 32'h4);
		accumulated_phase <= 32'h40000000;
		repeat (25) @(posedge clk);
		near("binary sine", 16'h7FFF, sine_out ^ 16'h8000);
		near("binary cosine", 16'h0000, cosine_out ^ 16'h8000);
		pqo_serial_sink_inst.receive(sm, sl, cm, cl, stb, tail);
		check("parallel strobe", 32'hFFFF, {16'h0000, stb});
		xfer(1'b1, pqo_pkg::CTRL_OFFSET, 32'h2);
		repeat (25) @(posedge clk);
		pqo_serial_sink_inst.receive(sm, sl, cm, cl, stb, tail);
		check("strobe pattern", 32'h7FFF, {16'h0000, stb});
		near("serial sine", 16'h7FFF, sm);
		near("serial cosine", 16'h0000, cm);
		check("sine lsb stream", {16'h0000, sm}, {16'h0000, sl});
		check("cosine lsb stream", {16'h0000, cm}, {16'h0000, cl});
		check("stream tails", 32'h1, {31'h0, tail});
		end_sim();
	end
endmodule : testbench

`default_nettype wire
